// ### hw/intc_pkg.sv
// shared constants, register map and carrier types of the interrupt controller
package intc_pkg;
  localparam int NUM_SRC = 35;
  localparam int NUM_TRAP = 4;
  localparam int NUM_TRAP_VEC = 8;
  localparam int NUM_VEC = 126;
  localparam int MAX_SRC_VEC = 118;
  localparam int VEC_W = 24;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam int PENDING_VECTOR_NUMBER_W = 7;
  localparam int SRC_IDX_W = 6;
  localparam int PRIO_PER_WORD = 8;
  localparam int PRIO_FIELD_STRIDE = 4;
  localparam int NUM_PRIO_WORDS = 5;
  localparam int NUM_EV = 4;

  // program-memory layout of the tables; each entry is two address units wide
  localparam logic [VEC_W-1:0] PRIMARY_BASE = 24'h000004;
  localparam logic [VEC_W-1:0] ALT_BASE = 24'h000100;
  localparam logic [VEC_W-1:0] RESET_PC = 24'h000000;

  // register byte offsets
  localparam logic [11:0] ADDR_FLAG0 = 12'h000;
  localparam logic [11:0] ADDR_FLAG1 = 12'h004;
  localparam logic [11:0] ADDR_PRIO0 = 12'h008;
  localparam logic [11:0] ADDR_ADC_PAIR6_PRIO = 12'h018;
  localparam logic [11:0] ADDR_CTL2 = 12'h01C;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  localparam logic [11:0] ADDR_EVT_STAT = 12'h024;
  localparam logic [11:0] ADDR_EVT_MASK = 12'h028;
  localparam logic [11:0] ADDR_TRAP = 12'h02C;

  // field positions
  localparam int ALT_SEL_BIT = 15;
  localparam int LEVEL_LSB = 8;
  localparam int PENDING_VECTOR_NUMBER_LSB = 0;
  localparam int EXT0_BIT = 0;
  localparam int CAP1_BIT = 1;
  localparam int ADC_PAIR6_SRC = 34;
  localparam int EV_TAKEN = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_RETURN = 2;
  localparam int EV_SPURIOUS = 3;

  // reset values and fixed latencies
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [1:0] RET_CYCLES = 2'h2;

  typedef struct packed {
    logic valid;
    logic [SRC_IDX_W-1:0] idx;
    logic [PRIO_W-1:0] level;
  } win_s;

  typedef struct packed {
    logic [PENDING_VECTOR_NUMBER_W-1:0] vec;
    logic [VEC_W-1:0] addr;
  } entry_s;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DELIVER, ST_RETURN} state_e;
endpackage

// ### hw/src_arbiter.sv
// picks the highest-priority pending source, lower index winning ties
`timescale 1ns/1ns
module src_arbiter
  import intc_pkg::*;
(
  input wire logic [intc_pkg::NUM_SRC-1:0] pend, // pending flags
  input wire logic [intc_pkg::NUM_SRC-1:0][intc_pkg::PRIO_W-1:0] prio, // per-source level
  output intc_pkg::win_s win // winning source
);
  always_comb begin
    win = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // strict compare keeps the earlier vector on equal levels
      if (pend[i] && prio[i] != 3'h0 && (!win.valid || prio[i] > win.level)) begin
        win.valid = 1'b1;
        win.idx = SRC_IDX_W'(i);
        win.level = prio[i];
      end
    end
  end
endmodule

// ### hw/vector_addr_gen.sv
// turns a vector number and table select into the program address of its entry
`timescale 1ns/1ns
module vector_addr_gen
  import intc_pkg::*;
(
  input wire logic [intc_pkg::PENDING_VECTOR_NUMBER_W-1:0] vec, // vector number
  input wire logic alt_sel, // use the alternate table
  output logic [intc_pkg::VEC_W-1:0] addr // entry address
);
  always_comb begin
    addr = (alt_sel ? ALT_BASE : PRIMARY_BASE) + {16'h0, vec, 1'b0};
  end
endmodule

// ### hw/vectored_priority_interrupt_ctl.sv
// vectored priority interrupt controller with apb register access
//
// What this block does
// - all peripheral request lines merge into one request to the cpu core
// - primary table starts at 000004h, 126 entries: 8 traps then 118 sources
// - each entry is a 24-bit service routine start address fetched on entry
// - every source and trap owns its own distinct vector entry
// - equal user priority resolves by vector position, lower address wins
// - 35 maskable sources and 4 non-maskable traps are provided
// - 3-bit priority per source, 111 level 7, 001 level 1, 000 disabled
// - entry and return latencies are fixed cycle counts for every source
// - alt table select bit 15 of control register 2 redirects all fetches
// - alternate table follows the primary table with identical layout
// - reset clears registers except priorities (set to level 4), controller idle, pc restart address is zero
// - per-source flag reads 1 once requested; ext0 bit 0, capture1 bit 1
// - status bits 11:8 show the 4-bit cpu priority level, read only
// - cpu level is the top bit placed above core status bits 7:5
`timescale 1ns/1ns
module vectored_priority_interrupt_ctl
  import intc_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [intc_pkg::NUM_SRC-1:0] src_req, // peripheral request lines
  input wire logic [intc_pkg::NUM_TRAP-1:0] trap_req, // non-maskable trap lines
  input wire logic [2:0] core_status_word, // core level bits 7:5
  input wire logic priority_level_top_bit, // extra cpu level bit
  input wire logic cpu_ack, // core accepts the request
  input wire logic cpu_return, // core returns from a routine
  input wire logic [intc_pkg::VEC_W-1:0] vec_fetch_data, // table word, one cycle after fetch
  output logic cpu_irq, // merged request to the core
  output logic vec_fetch_en, // table read strobe
  output logic [intc_pkg::VEC_W-1:0] vec_fetch_addr, // table read address
  output logic isr_valid, // service routine address valid
  output intc_pkg::entry_s isr_entry, // taken vector and routine address
  output logic return_done, // return sequence finished
  output logic [intc_pkg::VEC_W-1:0] reset_pc, // restart address for the core
  output logic evt_irq // event interrupt to software
);
  import intc_pkg::*;

  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0][PRIO_W-1:0] prio_q;
  logic alt_sel_q;
  logic [NUM_EV-1:0] ev_q;
  logic [NUM_EV-1:0] ev_mask_q;
  logic [NUM_EV-1:0] ev_set;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cpu_irq_q;
  logic vec_fetch_en_q;
  logic [VEC_W-1:0] vec_fetch_addr_q;
  logic isr_valid_q;
  entry_s isr_entry_q;
  logic return_done_q;
  logic evt_irq_q;
  logic [PENDING_VECTOR_NUMBER_W-1:0] vec_q;
  logic [1:0] ret_cnt_q;
  state_e st_q;
  win_s win;
  logic [LEVEL_W-1:0] cpu_level;
  logic trap_any;
  logic [PENDING_VECTOR_NUMBER_W-1:0] trap_vec;
  logic req_d;
  logic [PENDING_VECTOR_NUMBER_W-1:0] take_vec;
  logic [VEC_W-1:0] entry_addr;
  logic wr_en;
  logic rd_setup;
  logic [31:0] rdata_d;
  logic err_d;
  logic ack_ok;
  logic ret_start;

  assign cpu_level = {priority_level_top_bit, core_status_word};
  assign trap_any = |trap_req;
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_setup = psel && !penable;

  // flags stay sticky; a request in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (src_req[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wr_en && paddr == ADDR_FLAG0 && i < 32 && pwdata[i % 32]) begin
          flag_q[i] <= 1'b0;
        end else if (wr_en && paddr == ADDR_FLAG1 && i >= 32 && pwdata[i % 32]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // priority fields sit one per nibble, eight sources to a word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= {NUM_SRC{PRIO_RESET}};
    end else if (wr_en) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (paddr == ADDR_PRIO0 + 12'(4 * (i / PRIO_PER_WORD))) begin
          prio_q[i] <= pwdata[PRIO_FIELD_STRIDE * (i % PRIO_PER_WORD) +: PRIO_W];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_sel_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_CTL2) begin
      alt_sel_q <= pwdata[ALT_SEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_mask_q <= '0;
    end else if (wr_en && paddr == ADDR_EVT_MASK) begin
      ev_mask_q <= pwdata[NUM_EV-1:0];
    end
  end

  // event status: write one to clear, a new event in the same cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= '0;
    end else if (wr_en && paddr == ADDR_EVT_STAT) begin
      ev_q <= (ev_q & ~pwdata[NUM_EV-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_irq_q <= 1'b0;
    end else begin
      evt_irq_q <= |(ev_q & ev_mask_q);
    end
  end

  src_arbiter u_arb (
    .pend(flag_q),
    .prio(prio_q),
    .win(win)
  );

  always_comb begin
    trap_vec = '0;
    for (int t = NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_req[t]) begin
        trap_vec = PENDING_VECTOR_NUMBER_W'(t);
      end
    end
  end

  // traps take vectors below NUM_TRAP_VEC, sources the ones after them
  assign take_vec = trap_any ? trap_vec
                  : PENDING_VECTOR_NUMBER_W'(win.idx) + PENDING_VECTOR_NUMBER_W'(NUM_TRAP_VEC);
  assign req_d = trap_any || (win.valid && {1'b0, win.level} > cpu_level);
  assign ack_ok = (st_q == ST_IDLE) && cpu_ack && cpu_irq_q;
  assign ret_start = (st_q == ST_IDLE) && cpu_return && !cpu_ack;

  vector_addr_gen u_vaddr (
    .vec(take_vec),
    .alt_sel(alt_sel_q),
    .addr(entry_addr)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_q <= 1'b0;
    end else begin
      cpu_irq_q <= req_d && (st_q == ST_IDLE) && !ack_ok && !ret_start;
    end
  end

  // entry and return run as fixed sequences, so the latency never depends on the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      vec_q <= '0;
      ret_cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (ack_ok) begin
            st_q <= ST_ADDR;
            vec_q <= take_vec;
          end else if (ret_start) begin
            st_q <= ST_RETURN;
            ret_cnt_q <= RET_CYCLES - 2'h1;
          end
        end
        ST_ADDR: st_q <= ST_DATA;
        ST_DATA: st_q <= ST_DELIVER;
        ST_DELIVER: st_q <= ST_IDLE;
        ST_RETURN: begin
          if (ret_cnt_q == 2'h0) begin
            st_q <= ST_IDLE;
          end else begin
            ret_cnt_q <= ret_cnt_q - 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_fetch_en_q <= 1'b0;
      vec_fetch_addr_q <= '0;
    end else begin
      vec_fetch_en_q <= ack_ok;
      if (ack_ok) begin
        vec_fetch_addr_q <= entry_addr;
      end
    end
  end

  // table memory answers one cycle after the strobe; word is taken in ST_DATA
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_valid_q <= 1'b0;
      isr_entry_q <= '0;
    end else begin
      isr_valid_q <= (st_q == ST_DATA);
      if (st_q == ST_DATA) begin
        isr_entry_q.vec <= vec_q;
        isr_entry_q.addr <= vec_fetch_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_done_q <= 1'b0;
    end else begin
      return_done_q <= (st_q == ST_RETURN) && (ret_cnt_q == 2'h0);
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[EV_TAKEN] = ack_ok && !trap_any;
    ev_set[EV_TRAP] = ack_ok && trap_any;
    ev_set[EV_RETURN] = (st_q == ST_RETURN) && (ret_cnt_q == 2'h0);
    ev_set[EV_SPURIOUS] = cpu_ack && !ack_ok;
  end

  // read data is captured in the setup phase, so the answer has zero wait states
  always_comb begin
    rdata_d = 32'h0;
    err_d = 1'b0;
    case (paddr)
      ADDR_FLAG0: rdata_d = flag_q[31:0];
      ADDR_FLAG1: rdata_d = {29'h0, flag_q[NUM_SRC-1:32]};
      ADDR_CTL2: rdata_d = {16'h0, alt_sel_q, 15'h0};
      ADDR_STATUS: rdata_d = {20'h0, cpu_level, 1'b0, 1'b0, win.idx};
      ADDR_EVT_STAT: rdata_d = {28'h0, ev_q};
      ADDR_EVT_MASK: rdata_d = {28'h0, ev_mask_q};
      ADDR_TRAP: rdata_d = {28'h0, trap_req};
      default: begin
        err_d = 1'b1;
        for (int w = 0; w < NUM_PRIO_WORDS; w++) begin
          if (paddr == ADDR_PRIO0 + 12'(4 * w)) begin
            err_d = 1'b0;
            for (int j = 0; j < PRIO_PER_WORD; j++) begin
              if (w * PRIO_PER_WORD + j < NUM_SRC) begin
                rdata_d[PRIO_FIELD_STRIDE * j +: PRIO_W] = prio_q[w * PRIO_PER_WORD + j];
              end
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (rd_setup) begin
        prdata_q <= pwrite ? 32'h0 : rdata_d;
        pslverr_q <= err_d;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_irq = cpu_irq_q;
  assign vec_fetch_en = vec_fetch_en_q;
  assign vec_fetch_addr = vec_fetch_addr_q;
  assign isr_valid = isr_valid_q;
  assign isr_entry = isr_entry_q;
  assign return_done = return_done_q;
  assign evt_irq = evt_irq_q;
  assign reset_pc = RESET_PC;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fetch;
    vec_fetch_en ##1 !vec_fetch_en;
  endsequence

  sequence s_deliver;
    isr_valid ##1 !isr_valid;
  endsequence

  chk_entry_latency: assert property (ack_ok |=> s_fetch ##1 s_deliver)
    else $error("entry sequence length wrong");

  chk_return_latency: assert property (ret_start |=> !return_done [*2] ##1 return_done)
    else $error("return sequence length wrong");

  chk_trap_request: assert property ((st_q == ST_IDLE && trap_any && !ack_ok && !ret_start)
    |=> cpu_irq)
    else $error("trap did not raise request");

  chk_level_gate: assert property ((!trap_any && !(win.valid && {1'b0, win.level} > cpu_level))
    |=> !cpu_irq)
    else $error("request raised at or below cpu level");

  chk_table_select: assert property (vec_fetch_en |-> vec_fetch_addr ==
    ($past(alt_sel_q) ? ALT_BASE : PRIMARY_BASE) + {16'h0, vec_q, 1'b0})
    else $error("vector fetched from wrong table");

  chk_isr_word: assert property (isr_valid |-> isr_entry.addr == $past(vec_fetch_data, 1))
    else $error("routine address not the fetched word");

  chk_flag_sticky: assert property (src_req[EXT0_BIT] |=> flag_q[EXT0_BIT])
    else $error("request flag not set");

  chk_natural_order: assert property ((flag_q[0] && flag_q[1] && prio_q[0] == prio_q[1]
    && prio_q[0] != 3'h0) |-> win.idx != 6'h01)
    else $error("later vector beat earlier one");

  chk_disabled_src: assert property (win.valid |-> prio_q[win.idx] != 3'h0)
    else $error("disabled source won arbitration");

  chk_status_level: assert property ((rd_setup && !pwrite && paddr == ADDR_STATUS)
    |=> prdata[11:8] == $past(cpu_level))
    else $error("status level field wrong");
endmodule

// ### tb/core_model.sv
// behavioural cpu core: acknowledges the merged request once per arming, serves table words
`timescale 1ns/1ns
module core_model
  import intc_pkg::*;
#(
  parameter logic [intc_pkg::VEC_W-1:0] WORD_KEY = 24'hA5C3E1
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic arm, // allow one acknowledge
  input wire logic [3:0] ack_delay, // cycles to wait before acking
  input wire logic cpu_irq, // merged request
  input wire logic vec_fetch_en, // table read strobe
  input wire logic [intc_pkg::VEC_W-1:0] vec_fetch_addr, // table read address
  output logic cpu_ack, // acknowledge pulse
  output logic [intc_pkg::VEC_W-1:0] vec_fetch_data // table word
);
  logic [3:0] wait_q;
  logic used_q;
  // one ack per arming, so a sticky request cannot trigger a stray second entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      used_q <= 1'b0;
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      if (!arm) begin
        used_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (!used_q && cpu_irq) begin
        if (wait_q == ack_delay) begin
          cpu_ack <= 1'b1;
          used_q <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
  // outside the answer cycle the word keeps toggling so a late sample cannot match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_fetch_data <= 24'h000000;
    end else if (vec_fetch_en) begin
      vec_fetch_data <= vec_fetch_addr ^ WORD_KEY;
    end else begin
      vec_fetch_data <= ~vec_fetch_data;
    end
  end
endmodule

// ### tb/vectored_priority_interrupt_ctl_tb.sv
// self-checking testbench of the interrupt controller
`timescale 1ns/1ns
module vectored_priority_interrupt_ctl_tb;
  import intc_pkg::*;
  localparam logic [23:0] KEY = 24'hA5C3E1;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [34:0] src_req;
  logic [3:0] trap_req, ack_delay;
  logic [2:0] core_status_word;
  logic priority_level_top_bit, cpu_ack, m_ack, tb_ack, cpu_return, arm;
  logic cpu_irq, vec_fetch_en, isr_valid, return_done, evt_irq;
  logic [23:0] vec_fetch_data, vec_fetch_addr, reset_pc, base;
  entry_s isr_entry, last_ent;
  logic [31:0] pw [5];
  int n_tests, fail_count, cyc, ack_cyc, ret_cyc, ent_lat, ret_lat, n_ent, n_ret, prev;
  assign cpu_ack = m_ack | tb_ack;

  vectored_priority_interrupt_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .trap_req(trap_req),
    .core_status_word(core_status_word), .priority_level_top_bit(priority_level_top_bit),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return), .vec_fetch_data(vec_fetch_data),
    .cpu_irq(cpu_irq), .vec_fetch_en(vec_fetch_en), .vec_fetch_addr(vec_fetch_addr),
    .isr_valid(isr_valid), .isr_entry(isr_entry), .return_done(return_done),
    .reset_pc(reset_pc), .evt_irq(evt_irq));
  core_model #(.WORD_KEY(KEY)) u_core (.pclk(pclk), .presetn(presetn), .arm(arm),
    .ack_delay(ack_delay), .cpu_irq(cpu_irq), .vec_fetch_en(vec_fetch_en),
    .vec_fetch_addr(vec_fetch_addr), .cpu_ack(m_ack), .vec_fetch_data(vec_fetch_data));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // latency monitor, counting edges between the sampled cause and the sampled answer
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cpu_ack === 1'b1 && cpu_irq === 1'b1) ack_cyc <= cyc;
    if (cpu_return === 1'b1) ret_cyc <= cyc;
    if (isr_valid === 1'b1) begin
      ent_lat <= cyc - ack_cyc;
      last_ent <= isr_entry;
      n_ent <= n_ent + 1;
    end
    if (return_done === 1'b1) begin
      ret_lat <= cyc - ret_cyc;
      n_ret <= n_ret + 1;
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_chg(ref int cnt, input int old);
    int k;
    k = 0;
    while (cnt == old && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (cnt == old) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic set_prio(input int s, input logic [2:0] p);
    pw[s / 8][4 * (s % 8) +: 3] = p;
    apb(1'b1, ADDR_PRIO0 + 12'(4 * (s / 8)), pw[s / 8]);
  endtask

  task automatic pulse_src(input logic [34:0] m);
    src_req <= m;
    @(posedge pclk);
    src_req <= 35'h0;
  endtask

  task automatic level(input logic [3:0] l);
    priority_level_top_bit <= l[3];
    core_status_word <= l[2:0];
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {src_req, trap_req, ack_delay, tb_ack, cpu_return, arm} = '0;
    {core_status_word, priority_level_top_bit} = '0;
    foreach (pw[i]) pw[i] = 32'h44444444;
    pw[4] = 32'h00000444;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk({8'h00, reset_pc}, 32'h00000000);
    apb(1'b0, ADDR_PRIO0, 32'h0);
    chk(rdata, 32'h44444444);
    apb(1'b0, ADDR_ADC_PAIR6_PRIO, 32'h0);
    chk(rdata, 32'h00000444);
    apb(1'b0, ADDR_CTL2, 32'h0);
    chk(rdata, 32'h00000000);
    apb(1'b0, 12'h030, 32'h0);
    chk({err, rdata}, {1'b1, 32'h00000000});
    for (int i = 0; i < 16; i++) begin
      level(4'(i));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rdata, {20'h0, 4'(i), 8'h00});
    end
    $display("test reset and level done");
    // cpu level is 15 here, so nothing may reach the core
    pulse_src(35'h400000003);
    apb(1'b0, ADDR_FLAG0, 32'h0);
    chk(rdata, 32'h00000003);
    apb(1'b0, ADDR_FLAG1, 32'h0);
    chk(rdata, 32'h00000004);
    chk({31'h0, cpu_irq}, 32'h0);
    apb(1'b1, ADDR_FLAG0, 32'h00000001);
    apb(1'b0, ADDR_FLAG0, 32'h0);
    chk(rdata, 32'h00000002);
    apb(1'b1, ADDR_FLAG0, 32'h00000002);
    apb(1'b1, ADDR_FLAG1, 32'h00000004);
    $display("test flags done");
    set_prio(3, 3'h5);
    set_prio(9, 3'h5);
    pulse_src(35'h000000208);
    level(4'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h00000003);
    set_prio(9, 3'h6);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h00000009);
    set_prio(9, 3'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h00000003);
    level(4'h5);
    chk({31'h0, cpu_irq}, 32'h0);
    level(4'hC);
    chk({31'h0, cpu_irq}, 32'h0);
    level(4'h4);
    chk({31'h0, cpu_irq}, 32'h1);
    $display("test arbitration done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CTL2, i ? 32'h00008000 : 32'h0);
      base = i ? ALT_BASE : PRIMARY_BASE;
      ack_delay <= i ? 4'h3 : 4'h0;
      prev = n_ent;
      arm <= 1'b1;
      wait_chg(n_ent, prev);
      arm <= 1'b0;
      chk(ent_lat, 32'h3);
      chk({25'h0, last_ent.vec}, 32'h0000000B);
      chk({8'h00, last_ent.addr}, {8'h00, (base + 24'h000016) ^ KEY});
      repeat (6) @(posedge pclk);
    end
    apb(1'b1, ADDR_CTL2, 32'h0);
    apb(1'b1, ADDR_FLAG0, 32'h00000208);
    $display("test source entry done");
    level(4'hF);
    trap_req <= 4'h6;
    repeat (3) @(posedge pclk);
    chk({31'h0, cpu_irq}, 32'h1);
    apb(1'b0, ADDR_TRAP, 32'h0);
    chk(rdata, 32'h00000006);
    prev = n_ent;
    arm <= 1'b1;
    wait_chg(n_ent, prev);
    arm <= 1'b0;
    trap_req <= 4'h0;
    chk(ent_lat, 32'h3);
    chk({25'h0, last_ent.vec}, 32'h00000001);
    chk({8'h00, last_ent.addr}, {8'h00, (PRIMARY_BASE + 24'h000002) ^ KEY});
    repeat (6) @(posedge pclk);
    prev = n_ret;
    cpu_return <= 1'b1;
    @(posedge pclk);
    cpu_return <= 1'b0;
    wait_chg(n_ret, prev);
    // done pulse is registered, so it shows one edge after the last return cycle
    chk(ret_lat, 32'(RET_CYCLES) + 32'h1);
    $display("test trap and return done");
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk(rdata, 32'h00000007);
    chk({31'h0, evt_irq}, 32'h0);
    apb(1'b1, ADDR_EVT_MASK, 32'h00000008);
    apb(1'b1, ADDR_EVT_STAT, 32'h0000000F);
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk(rdata, 32'h00000000);
    tb_ack <= 1'b1;
    @(posedge pclk);
    tb_ack <= 1'b0;
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk(rdata, 32'h00000008);
    chk({31'h0, evt_irq}, 32'h1);
    apb(1'b1, ADDR_EVT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, evt_irq}, 32'h0);
    apb(1'b1, ADDR_EVT_MASK, 32'h00000008);
    apb(1'b1, ADDR_EVT_STAT, 32'h00000008);
    repeat (2) @(posedge pclk);
    chk({31'h0, evt_irq}, 32'h0);
    $display("test events done");
    summarize();
  end
endmodule
